/* File: logic/timer16_pkg.sv */
// constants shared by the 16-bit free-running timer core
// assumes a 32-bit axi4-lite slave with word-aligned registers
package timer16_pkg;
   // ***********************************************
   // register byte offsets
   // ***********************************************
   localparam logic [7:0] counter_high_byte_off     = 8'h00;
   localparam logic [7:0] counter_low_byte_off      = 8'h04;
   localparam logic [7:0] alt_counter_high_byte_off = 8'h08;
   localparam logic [7:0] alt_counter_low_byte_off  = 8'h0C;
   localparam logic [7:0] timer_status_reg_off      = 8'h10;
   localparam logic [7:0] timer_control_one_off     = 8'h14;
   localparam logic [7:0] timer_control_two_off     = 8'h18;
   localparam logic [7:0] irq_status_off            = 8'h1C;
   localparam logic [7:0] irq_mask_off              = 8'h20;
   // ***********************************************
   // fields and values
   // ***********************************************
   localparam int          overflow_flag_bit       = 7;
   localparam int          overflow_irq_enable_bit = 5;
   localparam int          ext_edge_select_bit     = 0;
   localparam int          clock_select_lsb        = 2;
   localparam logic [15:0] count_reset_value       = 16'hFFFC;
   localparam logic [15:0] count_max               = 16'hFFFF;
   localparam logic [1:0]  cs_div4                 = 2'h0;
   localparam logic [1:0]  cs_div2                 = 2'h1;
   localparam logic [1:0]  cs_div8                 = 2'h2;
   localparam logic [1:0]  cs_external             = 2'h3;
   localparam logic [2:0]  div2_mask               = 3'h1;
   localparam logic [2:0]  div4_mask               = 3'h3;
   localparam logic [2:0]  div8_mask               = 3'h7;
   localparam logic [1:0]  resp_okay               = 2'h0;
   localparam logic [1:0]  resp_slverr             = 2'h2;
endpackage

/* File: logic/timer16_core.sv */
// 16-bit free-running timer core with axi4-lite register access
// assumes ext_clock_pin is asynchronous; cpu_irq_mask and halt_mode come from the core clock
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module timer16_core #(
   parameter bit ext_pin_bonded = 1'b1 // zero when the pin is not bonded out
) (
   input  wire logic        aclk,          // core clock, 200 MHz
   input  wire logic        aresetn,       // synchronous reset, active low
   input  wire logic        ext_clock_pin, // external timer clock pin
   input  wire logic        cpu_irq_mask,  // cpu interrupt mask, high blocks timer_irq
   input  wire logic        halt_mode,     // high while device halted
   input  wire logic        wait_mode,     // high while device waits
   output      logic        timer_irq,     // overflow interrupt request
   output      logic        irq,           // masked sticky interrupt level
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output      logic        s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output      logic        s_axi_wready,  // write data ready
   output      logic [1:0]  s_axi_bresp,   // write response
   output      logic        s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output      logic        s_axi_arready, // read address ready
   output      logic [31:0] s_axi_rdata,   // read data
   output      logic [1:0]  s_axi_rresp,   // read response
   output      logic        s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready   // read data ready
);
   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [15:0] count;
      logic [2:0]  presc;
      logic [1:0]  ext_sync;
      logic        ext_prev;
      logic [7:0]  low_latch;
      logic        latch_open;
      logic        overflow_flag;
      logic        clear_armed;
      logic        overflow_irq_enable;
      logic [1:0]  clock_select_field;
      logic        ext_edge_select;
      logic        irq_status;
      logic        irq_mask;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_t;

   state_t st;
   state_t next_st;

   logic       ext_level;
   logic       tick;
   logic       wrap;
   logic       wr_go;
   logic       rd_go;
   logic [2:0] div_mask;
   logic [7:0] rd_byte;
   logic       rd_ok;

   assign ext_level     = ext_pin_bonded ? ext_clock_pin : 1'b1;
   assign s_axi_awready = !st.aw_held;
   assign s_axi_wready  = !st.w_held;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign irq           = st.irq_status && st.irq_mask;
   assign timer_irq     = st.overflow_flag && st.overflow_irq_enable && !cpu_irq_mask;

   always_comb
   begin
      next_st = st;
      // ***********************************************
      // clock source
      // ***********************************************
      next_st.ext_sync = {st.ext_sync[0], ext_level};
      next_st.ext_prev = st.ext_sync[1];
      case (st.clock_select_field)
         timer16_pkg::cs_div4: div_mask = timer16_pkg::div4_mask;
         timer16_pkg::cs_div2: div_mask = timer16_pkg::div2_mask;
         timer16_pkg::cs_div8: div_mask = timer16_pkg::div8_mask;
         default:              div_mask = timer16_pkg::div8_mask;
      endcase
      if (!halt_mode)
      begin
         next_st.presc = st.presc + 3'h1;
      end
      if (st.clock_select_field == timer16_pkg::cs_external)
      begin
         tick = !halt_mode && (st.ext_edge_select ?
                (st.ext_sync[1] && !st.ext_prev) : (!st.ext_sync[1] && st.ext_prev));
      end
      else
      begin
         tick = !halt_mode && ((st.presc & div_mask) == div_mask);
      end
      wrap = tick && (st.count == timer16_pkg::count_max);
      if (tick)
      begin
         next_st.count = st.count + 16'h0001;
      end
      if (wrap)
      begin
         next_st.irq_status = 1'b1;
      end
      // ***********************************************
      // write channel
      // ***********************************************
      if (s_axi_awvalid && !st.aw_held)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_held)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      wr_go = st.aw_held && st.w_held && !st.bvalid;
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = timer16_pkg::resp_okay;
         case (st.aw_addr)
            timer16_pkg::counter_low_byte_off:
            begin
               next_st.count = timer16_pkg::count_reset_value;
               if (st.clear_armed)
               begin
                  next_st.clear_armed   = 1'b0;
                  next_st.overflow_flag = 1'b0;
               end
            end
            timer16_pkg::alt_counter_low_byte_off:
               next_st.count = timer16_pkg::count_reset_value;
            timer16_pkg::timer_control_one_off:
               if (st.w_strb[0])
               begin
                  next_st.overflow_irq_enable = st.w_data[timer16_pkg::overflow_irq_enable_bit];
               end
            timer16_pkg::timer_control_two_off:
               if (st.w_strb[0])
               begin
                  next_st.ext_edge_select    = st.w_data[timer16_pkg::ext_edge_select_bit];
                  next_st.clock_select_field =
                     st.w_data[timer16_pkg::clock_select_lsb +: 2];
               end
            timer16_pkg::irq_status_off:
               if (st.w_strb[0] && st.w_data[0] && !wrap)
               begin
                  next_st.irq_status = 1'b0;
               end
            timer16_pkg::irq_mask_off:
               if (st.w_strb[0])
               begin
                  next_st.irq_mask = st.w_data[0];
               end
            timer16_pkg::counter_high_byte_off,
            timer16_pkg::alt_counter_high_byte_off,
            timer16_pkg::timer_status_reg_off: ;
            default: next_st.bresp = timer16_pkg::resp_slverr;
         endcase
      end
      // ***********************************************
      // read channel
      // ***********************************************
      rd_go   = s_axi_arvalid && !st.rvalid;
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (rd_go)
      begin
         case (s_axi_araddr)
            timer16_pkg::counter_high_byte_off,
            timer16_pkg::alt_counter_high_byte_off:
            begin
               rd_byte = st.count[15:8];
               if (!st.latch_open)
               begin
                  next_st.low_latch  = st.count[7:0];
                  next_st.latch_open = 1'b1;
               end
            end
            timer16_pkg::counter_low_byte_off,
            timer16_pkg::alt_counter_low_byte_off:
            begin
               rd_byte            = st.latch_open ? st.low_latch : st.count[7:0];
               next_st.latch_open = 1'b0;
               if (s_axi_araddr == timer16_pkg::counter_low_byte_off && st.clear_armed)
               begin
                  next_st.clear_armed   = 1'b0;
                  next_st.overflow_flag = 1'b0;
               end
            end
            timer16_pkg::timer_status_reg_off:
            begin
               rd_byte = 8'(st.overflow_flag) << timer16_pkg::overflow_flag_bit;
               next_st.clear_armed = st.overflow_flag;
            end
            timer16_pkg::timer_control_one_off:
               rd_byte = 8'(st.overflow_irq_enable) << timer16_pkg::overflow_irq_enable_bit;
            timer16_pkg::timer_control_two_off:
               rd_byte = {4'h0, st.clock_select_field, 1'b0, st.ext_edge_select};
            timer16_pkg::irq_status_off: rd_byte = {7'h00, st.irq_status};
            timer16_pkg::irq_mask_off:   rd_byte = {7'h00, st.irq_mask};
            default:                     rd_ok = 1'b0;
         endcase
         next_st.rvalid = 1'b1;
         next_st.rdata  = {24'h000000, rd_byte};
         next_st.rresp  = rd_ok ? timer16_pkg::resp_okay : timer16_pkg::resp_slverr;
      end
      if (wrap) // set wins over clear
      begin
         next_st.overflow_flag = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st       <= '0;
         st.count <= timer16_pkg::count_reset_value;
         st.ext_sync <= 2'h3;
         st.ext_prev <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_status_read;
      rd_go && s_axi_araddr == timer16_pkg::timer_status_reg_off && st.overflow_flag;
   endsequence
   sequence s_main_low_read;
      rd_go && s_axi_araddr == timer16_pkg::counter_low_byte_off && !wrap;
   endsequence
   a_wrap_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      wrap |=> st.overflow_flag) else $error("overflow flag not set on wrap");
   a_reset_count: assert property (@(posedge aclk)
      !aresetn |=> st.count == timer16_pkg::count_reset_value) else $error("bad reset count");
   a_low_write_force: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && (st.aw_addr == timer16_pkg::counter_low_byte_off ||
      st.aw_addr == timer16_pkg::alt_counter_low_byte_off)
      |=> st.count == timer16_pkg::count_reset_value) else $error("low write missed");
   a_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_mode && !wr_go |=> $stable(st.count)) else $error("count moved in halt");
   a_two_step_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_status_read ##1 (!rd_go && !wr_go)[*1] ##1 s_main_low_read |=> !st.overflow_flag)
      else $error("two-step clear failed");
   a_alt_keeps_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && s_axi_araddr == timer16_pkg::alt_counter_low_byte_off && st.overflow_flag
      |=> st.overflow_flag) else $error("alternate read cleared flag");
   a_latched_low: assert property (@(posedge aclk) disable iff (!aresetn)
      st.latch_open && rd_go && s_axi_araddr == timer16_pkg::counter_low_byte_off
      |=> s_axi_rdata[7:0] == $past(st.low_latch)) else $error("latched low byte lost");
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_irq |-> st.overflow_flag && !cpu_irq_mask) else $error("stray timer irq");
   a_div2_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && st.clock_select_field == timer16_pkg::cs_div2 && !halt_mode ##1
      (st.clock_select_field == timer16_pkg::cs_div2 && !halt_mode && !wr_go) |-> !tick)
      else $error("div2 ticked twice in a row");
   // a counter write in the same cycle wins over the step
   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && !wr_go |=> st.count == $past(st.count) + 16'h0001)
      else $error("count did not step");
   sequence s_high_read;
      rd_go && (s_axi_araddr == timer16_pkg::counter_high_byte_off ||
      s_axi_araddr == timer16_pkg::alt_counter_high_byte_off);
   endsequence
   a_views_match: assert property (@(posedge aclk) disable iff (!aresetn)
      s_high_read |=> s_axi_rdata[7:0] == $past(st.count[15:8]))
      else $error("high byte differs from count");
   a_latch_on_high: assert property (@(posedge aclk) disable iff (!aresetn)
      s_high_read ##0 !st.latch_open
      |=> st.latch_open && st.low_latch == $past(st.count[7:0]))
      else $error("low byte not latched");
   a_live_low: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && !st.latch_open && (s_axi_araddr == timer16_pkg::counter_low_byte_off ||
      s_axi_araddr == timer16_pkg::alt_counter_low_byte_off)
      |=> s_axi_rdata[7:0] == $past(st.count[7:0])) else $error("live low byte wrong");
   a_alt_write_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && st.aw_addr == timer16_pkg::alt_counter_low_byte_off &&
      st.overflow_flag && !rd_go
      |=> st.overflow_flag) else $error("alternate write cleared flag");
   a_unarmed_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && s_axi_araddr == timer16_pkg::counter_low_byte_off && !st.clear_armed &&
      st.overflow_flag && !wr_go
      |=> st.overflow_flag) else $error("unarmed low read cleared flag");
   a_irq_pending: assert property (@(posedge aclk) disable iff (!aresetn)
      st.overflow_flag && st.overflow_irq_enable && !cpu_irq_mask |-> timer_irq)
      else $error("pending overflow irq not raised");
   a_halt_presc: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_mode |=> $stable(st.presc)) else $error("prescaler moved in halt");
   a_wait_runs: assert property (@(posedge aclk) disable iff (!aresetn)
      wait_mode && !halt_mode |=> !$stable(st.presc)) else $error("prescaler stopped in wait");
   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid) else $error("write answer missing");
   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go |=> s_axi_rvalid) else $error("read answer missing");
endmodule

/* File: verification/ext_clock_source.sv */
// model of the source feeding the timer's external clock pin
// assumes edges() is called right after a rising aclk edge
`timescale 1ns/1ps
module ext_clock_source (
   input  wire logic aclk, // core clock
   output      logic pin   // external clock pin level
);
   // ****************
   // pin driver
   // ****************
   initial pin = 1'b0;
   // six clocks apart keeps well clear of the minimum spacing
   task automatic edges(input int n);
      repeat (n)
      begin
         repeat (6) @(posedge aclk);
         pin <= ~pin;
      end
   endtask
endmodule

/* File: verification/free_running_timer_counter16_tb_top.sv */
// self-checking bench for the 16-bit timer core
// assumes halt_mode freezes the count at once and axi answers per the core's handshake
`timescale 1ns/1ps
module free_running_timer_counter16_tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        ext_pin;
   logic        cpu_irq_mask = 1'b0;
   logic        halt_mode = 1'b1;
   logic        wait_mode = 1'b0;
   logic        timer_irq, irq, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] ca, cb;
   int          err_total = 0;
   int          comparisons = 0;

   always #2.5 aclk = ~aclk;

   timer16_core i_dut (
      .aclk(aclk), .aresetn(aresetn), .ext_clock_pin(ext_pin),
      .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode), .wait_mode(wait_mode),
      .timer_irq(timer_irq), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   ext_clock_source i_src (.aclk(aclk), .pin(ext_pin));

   // ****************
   // bus and check helpers
   // ****************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // ready is looked at on the falling edge so the taking edge is never raced
   // bready and rready stay high once raised, so back-to-back calls never retoggle them
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic da, dw;
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw))
      begin
         @(negedge aclk);
         da = da || awready;
         dw = dw || wready;
         @(posedge aclk);
         if (da) awvalid <= 1'b0;
         if (dw) wvalid <= 1'b0;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      chk(bresp, timer16_pkg::resp_okay);
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      @(posedge aclk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a, d, r);
      chk(d, e);
      chk(r, timer16_pkg::resp_okay);
   endtask

   // alternate view keeps the overflow flag out of the way
   task automatic cnt(output logic [15:0] c);
      rd(timer16_pkg::alt_counter_high_byte_off, d, r);
      c[15:8] = d[7:0];
      rd(timer16_pkg::alt_counter_low_byte_off, d, r);
      c[7:0] = d[7:0];
   endtask

   task automatic run(input int n);
      halt_mode <= 1'b0;
      repeat (n) @(posedge aclk);
      halt_mode <= 1'b1;
   endtask

   task automatic cs(input logic [1:0] c, input logic e);
      wr(timer16_pkg::timer_control_two_off, (32'(c) << timer16_pkg::clock_select_lsb) | 32'(e));
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      rc(timer16_pkg::counter_high_byte_off, 32'h000000FF);
      rc(timer16_pkg::counter_low_byte_off, 32'h000000FC);
      rc(timer16_pkg::alt_counter_high_byte_off, 32'h000000FF);
      rc(timer16_pkg::alt_counter_low_byte_off, 32'h000000FC);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000000);
      repeat (40) @(posedge aclk);
      rc(timer16_pkg::alt_counter_low_byte_off, 32'h000000FC);
   endtask

   task automatic t_prescale;
      logic [1:0] code [3] = '{timer16_pkg::cs_div4, timer16_pkg::cs_div2, timer16_pkg::cs_div8};
      int         dv [3] = '{4, 2, 8};
      wait_mode <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         cs(code[i], 1'b0);
         cnt(ca);
         run(8 * dv[i]);
         cnt(cb);
         chk(16'(cb - ca), 32'h00000008);
      end
      wait_mode <= 1'b0;
   endtask

   task automatic t_latch;
      cs(timer16_pkg::cs_div2, 1'b0);
      wr(timer16_pkg::counter_low_byte_off, 32'h0);
      rc(timer16_pkg::counter_high_byte_off, 32'h000000FF);
      run(8);
      rc(timer16_pkg::counter_high_byte_off, 32'h00000000);
      rc(timer16_pkg::counter_low_byte_off, 32'h000000FC);
      rc(timer16_pkg::counter_low_byte_off, 32'h00000000);
   endtask

   task automatic t_overflow;
      wr(timer16_pkg::timer_control_one_off, 32'h00000020);
      wr(timer16_pkg::irq_mask_off, 32'h00000001);
      rd(timer16_pkg::timer_status_reg_off, d, r);
      wr(timer16_pkg::alt_counter_low_byte_off, 32'h0);
      wr(timer16_pkg::counter_low_byte_off, 32'h0);
      wr(timer16_pkg::irq_status_off, 32'h00000001);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000000);
      chk(timer_irq, 32'h0);
      run(8);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000080);
      chk(timer_irq, 32'h1);
      chk(irq, 32'h1);
      cpu_irq_mask <= 1'b1;
      @(negedge aclk);
      chk(timer_irq, 32'h0);
      @(posedge aclk);
      cpu_irq_mask <= 1'b0;
      rc(timer16_pkg::alt_counter_low_byte_off, 32'h00000000);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000080);
      rc(timer16_pkg::counter_low_byte_off, 32'h00000000);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000000);
      wr(timer16_pkg::irq_mask_off, 32'h0);
      chk(irq, 32'h0);
      wr(timer16_pkg::irq_mask_off, 32'h00000001);
      chk(irq, 32'h1);
      wr(timer16_pkg::irq_status_off, 32'h00000001);
      chk(irq, 32'h0);
      rd(8'h40, d, r);
      chk(r, timer16_pkg::resp_slverr);
      chk(d, 32'h0);
   endtask

   // pin starts low: four toggles give two rises, two more give one fall
   task automatic t_external;
      cs(timer16_pkg::cs_external, 1'b1);
      wr(timer16_pkg::counter_low_byte_off, 32'h0);
      halt_mode <= 1'b0;
      i_src.edges(4);
      repeat (8) @(posedge aclk);
      cnt(ca);
      chk(ca, 32'h0000FFFE);
      cs(timer16_pkg::cs_external, 1'b0);
      i_src.edges(2);
      repeat (8) @(posedge aclk);
      cnt(ca);
      chk(ca, 32'h0000FFFF);
      halt_mode <= 1'b1;
   endtask

   // a reset in mid-run must restart from the reset count and default clocking
   task automatic t_rewake;
      cs(timer16_pkg::cs_div2, 1'b1);
      run(8);
      cnt(ca);
      chk(ca, 32'h00000003);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(timer16_pkg::alt_counter_high_byte_off, 32'h000000FF);
      rc(timer16_pkg::alt_counter_low_byte_off, 32'h000000FC);
      rc(timer16_pkg::timer_status_reg_off, 32'h00000000);
      rc(timer16_pkg::timer_control_two_off, 32'h00000000);
   endtask

   task automatic stop_test;
      if (err_total == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_prescale;
      t_latch;
      t_overflow;
      t_external;
      t_rewake;
      stop_test;
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      stop_test;
   end
endmodule
